// ### pkg/rst_seq_pkg.sv
package rst_seq_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int POR_DLY_NS = 1000;
	localparam int POR_DLY_CYC = (POR_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int PUD_MS = 64;
	localparam int SLOW_OSC_HZ = 31_000;
	localparam int PUD_TICKS = PUD_MS * SLOW_OSC_HZ / 1000;
	localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_OSC_HZ;
	localparam int OSU_CYCLES = 1024;
	localparam int BOR_MIN_NS = 100;
	localparam int BOR_MIN_CYC = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int REARM_MIN_NS = 1000;
	localparam int REARM_MIN_CYC = (REARM_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int PIN_FILTER_NS = 200;
	localparam int PIN_FILTER_CYC = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;

	// ----------------------------------------------------------------
	// Calibration word
	// ----------------------------------------------------------------
	localparam int CAL_WIDTH = 14;
	localparam int PROG_ADDR_W = 14;
	localparam logic [PROG_ADDR_W-1:0] CAL_WORD_ADDR = 14'h2008;

	// ----------------------------------------------------------------
	// Brown-out mode field
	// ----------------------------------------------------------------
	localparam logic [1:0] BOR_MODE_OFF = 2'h0;
	localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
	localparam logic [1:0] BOR_MODE_HW_SLEEP = 2'h2;
	localparam logic [1:0] BOR_MODE_ON = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_CRYSTAL,
		OSC_RC,
		OSC_EXT_CLOCK,
		OSC_INTERNAL
	} osc_mode_t;

	typedef struct packed {
		logic ext_reset_pin_enable;
		logic powerup_delay_enable_n;
		logic [1:0] brownout_mode_select;
		osc_mode_t osc_mode;
		logic two_speed_en;
		logic fail_safe_en;
	} fuse_t;

	typedef enum logic [2:0] {
		CAUSE_NONE,
		CAUSE_POR,
		CAUSE_WDT_RUN,
		CAUSE_WDT_SLEEP,
		CAUSE_PIN_RUN,
		CAUSE_PIN_SLEEP,
		CAUSE_BOR
	} cause_t;

	typedef struct packed {
		logic por_flag_n;
		logic brownout_flag_n;
		logic timeout_flag;
		logic sleep_flag_n;
	} flags_t;

	localparam flags_t FLAGS_RESET = 4'h3;

endpackage

// ### rtl/level_filter.sv
module level_filter #(
	parameter int MIN_CYC = 10
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// Level
	input wire logic active_in,
	output logic level_out
);

	localparam int W = $clog2(MIN_CYC + 2);
	localparam logic [W-1:0] MAX = W'(MIN_CYC);

	if (MIN_CYC < 1) begin : g_bad_min
		$error("level_filter needs MIN_CYC of at least 1");
	end

	logic [W-1:0] cnt_q;

	// ----------------------------------------------------------------
	// Width counter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= '0;
		end else if (!active_in) begin
			cnt_q <= '0;
		end else if (cnt_q != MAX) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			level_out <= 1'b0;
		end else begin
			level_out <= active_in && (cnt_q == MAX);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_filter_drop: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!active_in |=> !level_out)
		else $error("filter output stayed up after input dropped");

	a_filter_short: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		$rose(level_out) |-> $past(cnt_q) == MAX)
		else $error("filter passed a pulse below the minimum width");

endmodule

// ### rtl/mcu_reset_sequencer.sv
module mcu_reset_sequencer
	import rst_seq_pkg::*;
#(
	parameter int SLOW_DIV = SLOW_DIV_CYC,
	parameter int PUD_LEN = PUD_TICKS,
	parameter int OSU_LEN = OSU_CYCLES,
	parameter int POR_DLY = POR_DLY_CYC,
	parameter int BOR_MIN = BOR_MIN_CYC,
	parameter int REARM_MIN = REARM_MIN_CYC,
	parameter int PIN_MIN = PIN_FILTER_CYC,
	parameter int CAL_W = CAL_WIDTH
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// Supply comparators
	input wire logic supply_below_rearm_in,
	input wire logic supply_above_por_in,
	input wire logic supply_above_bor_in,
	// Reset sources and state
	input wire logic ext_reset_pin_n_in,
	input wire logic watchdog_timeout_in,
	input wire logic sleeping_in,
	input wire logic osc_tick_in,
	// Configuration and software bits
	input wire fuse_t fuses_in,
	input wire logic soft_brownout_enable_in,
	input wire logic sw_por_flag_set_in,
	input wire logic sw_bor_flag_set_in,
	// Programming port
	input wire logic prog_mode_in,
	input wire logic [PROG_ADDR_W-1:0] prog_addr_in,
	input wire logic prog_wr_in,
	input wire logic [CAL_W-1:0] prog_data_in,
	output logic [CAL_W-1:0] prog_rd_data_out,
	// Reset outputs
	output logic reg_reset_out,
	output logic use_internal_osc_out,
	output logic watchdog_wake_out,
	output cause_t reset_cause_out,
	output flags_t flags_out,
	// Analog and pin control
	output logic brownout_detect_en_out,
	output logic [CAL_W-1:0] bor_cal_out,
	output logic ext_reset_pin_out,
	output logic ext_reset_pin_oe_n_out,
	output logic ext_reset_pin_pullup_out,
	output logic prog_voltage_en_out
);

	if (SLOW_DIV < 2 || SLOW_DIV >= 2 ** CNT_W || PUD_LEN < 1 ||
		PUD_LEN >= 2 ** CNT_W || OSU_LEN < 1 || OSU_LEN >= 2 ** CNT_W ||
		POR_DLY < 1 || POR_DLY >= 2 ** CNT_W) begin : g_bad_param
		$error("mcu_reset_sequencer count parameter out of range");
	end

	typedef enum logic [2:0] {
		ST_POR,
		ST_POR_DLY,
		ST_BOR_WAIT,
		ST_PUD,
		ST_OSU,
		ST_PIN_HOLD,
		ST_RUN
	} state_t;

	state_t state_q;
	state_t state_d;
	state_t after_bor;
	state_t after_pud;
	state_t done_state;
	logic [CNT_W-1:0] div_q;
	logic [CNT_W-1:0] tmr_q;
	logic slow_tick;
	logic powerup_q;
	logic sleeping_q;
	logic ev;
	logic wake_ev;
	cause_t ev_cause;
	logic bor_active;
	logic bor_trip;
	logic rearm_trip;
	logic pin_trip;
	logic pin_low;
	logic pud_en;
	logic crystal;
	logic two_speed;
	logic [CAL_W-1:0] cal_q;

	// ----------------------------------------------------------------
	// Filters
	// ----------------------------------------------------------------
	level_filter #(.MIN_CYC(PIN_MIN)) u_pin_filter (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.active_in(!ext_reset_pin_n_in),
		.level_out(pin_trip)
	);

	level_filter #(.MIN_CYC(BOR_MIN)) u_bor_filter (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.active_in(bor_active && !supply_above_bor_in),
		.level_out(bor_trip)
	);

	level_filter #(.MIN_CYC(REARM_MIN)) u_rearm_filter (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.active_in(supply_below_rearm_in),
		.level_out(rearm_trip)
	);

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	always_comb begin
		unique case (fuses_in.brownout_mode_select)
			BOR_MODE_OFF: bor_active = 1'b0;
			BOR_MODE_SOFT: bor_active = soft_brownout_enable_in;
			BOR_MODE_HW_SLEEP: bor_active = !sleeping_in;
			BOR_MODE_ON: bor_active = 1'b1;
		endcase
	end

	assign pin_low = fuses_in.ext_reset_pin_enable && pin_trip;
	assign pud_en = !fuses_in.powerup_delay_enable_n;
	assign crystal = fuses_in.osc_mode == OSC_CRYSTAL;
	assign two_speed = fuses_in.two_speed_en || fuses_in.fail_safe_en;

	// ----------------------------------------------------------------
	// Slow oscillator divider
	// ----------------------------------------------------------------
	assign slow_tick = div_q == CNT_W'(SLOW_DIV - 1);

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= '0;
		end else if (slow_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		done_state = pin_low ? ST_PIN_HOLD : ST_RUN;
		after_pud = crystal ? ST_OSU : done_state;
		if (powerup_q && pud_en) begin
			after_bor = ST_PUD;
		end else if (powerup_q && crystal) begin
			after_bor = ST_OSU;
		end else begin
			after_bor = done_state;
		end
	end

	always_comb begin
		state_d = state_q;
		ev = 1'b0;
		wake_ev = 1'b0;
		ev_cause = CAUSE_NONE;
		if (rearm_trip) begin
			state_d = ST_POR;
			ev = 1'b1;
			ev_cause = CAUSE_POR;
		end else if (bor_trip && state_q inside {ST_OSU, ST_PIN_HOLD,
			ST_RUN}) begin
			state_d = ST_BOR_WAIT;
			ev = 1'b1;
			ev_cause = CAUSE_BOR;
		end else begin
			unique case (state_q)
				ST_POR: begin
					if (supply_above_por_in) begin
						state_d = ST_POR_DLY;
					end
				end
				ST_POR_DLY: begin
					if (tmr_q == CNT_W'(POR_DLY - 1)) begin
						state_d = ST_BOR_WAIT;
					end
				end
				ST_BOR_WAIT: begin
					if (!bor_active || supply_above_bor_in) begin
						state_d = after_bor;
					end
				end
				ST_PUD: begin
					if (bor_active && !supply_above_bor_in) begin
						state_d = ST_BOR_WAIT;
						ev = 1'b1;
						ev_cause = CAUSE_BOR;
					end else if (slow_tick &&
						tmr_q == CNT_W'(PUD_LEN - 1)) begin
						state_d = after_pud;
					end
				end
				ST_OSU: begin
					if (osc_tick_in && tmr_q == CNT_W'(OSU_LEN - 1)) begin
						state_d = done_state;
					end
				end
				ST_PIN_HOLD: begin
					if (!pin_low) begin
						state_d = (!bor_active || supply_above_bor_in) ?
							ST_RUN : ST_BOR_WAIT;
					end
				end
				ST_RUN: begin
					if (pin_low) begin
						state_d = ST_PIN_HOLD;
						ev = 1'b1;
						ev_cause = sleeping_in ? CAUSE_PIN_SLEEP :
							CAUSE_PIN_RUN;
					end else if (watchdog_timeout_in && sleeping_in) begin
						wake_ev = 1'b1;
						ev_cause = CAUSE_WDT_SLEEP;
					end else if (watchdog_timeout_in) begin
						state_d = ST_BOR_WAIT;
						ev = 1'b1;
						ev_cause = CAUSE_WDT_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ST_POR;
		end else begin
			state_q <= state_d;
		end
	end

	// Stage timer, cleared on every stage entry
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tmr_q <= '0;
		end else if (ev || state_d != state_q) begin
			tmr_q <= '0;
		end else if (state_q == ST_POR_DLY ||
			(state_q == ST_PUD && slow_tick) ||
			(state_q == ST_OSU && osc_tick_in)) begin
			tmr_q <= tmr_q + 1'b1;
		end
	end

	// Timers only follow power-on or brown-out
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			powerup_q <= 1'b1;
		end else if (ev && ev_cause inside {CAUSE_POR, CAUSE_BOR}) begin
			powerup_q <= 1'b1;
		end else if (state_d inside {ST_RUN, ST_PIN_HOLD}) begin
			powerup_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Cause flags
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sleeping_q <= 1'b0;
			reset_cause_out <= CAUSE_POR;
			flags_out <= FLAGS_RESET;
		end else begin
			sleeping_q <= sleeping_in;
			if (sw_por_flag_set_in) begin
				flags_out.por_flag_n <= 1'b1;
			end
			if (sw_bor_flag_set_in) begin
				flags_out.brownout_flag_n <= 1'b1;
			end
			if (sleeping_in && !sleeping_q) begin
				flags_out.sleep_flag_n <= 1'b0;
				flags_out.timeout_flag <= 1'b1;
			end
			if (ev || wake_ev) begin
				reset_cause_out <= ev_cause;
				unique case (ev_cause)
					CAUSE_POR: begin
						flags_out.por_flag_n <= 1'b0;
						flags_out.timeout_flag <= 1'b1;
						flags_out.sleep_flag_n <= 1'b1;
					end
					CAUSE_BOR: begin
						flags_out.brownout_flag_n <= 1'b0;
						flags_out.timeout_flag <= 1'b1;
						flags_out.sleep_flag_n <= 1'b1;
					end
					CAUSE_WDT_RUN: begin
						flags_out.timeout_flag <= 1'b0;
					end
					CAUSE_WDT_SLEEP: begin
						flags_out.timeout_flag <= 1'b0;
						flags_out.sleep_flag_n <= 1'b0;
					end
					CAUSE_PIN_SLEEP: begin
						flags_out.timeout_flag <= 1'b1;
						flags_out.sleep_flag_n <= 1'b0;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset and clock outputs
	// ----------------------------------------------------------------
	// Persistent registers take no line from here at all
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_reset_out <= 1'b1;
			use_internal_osc_out <= 1'b0;
			watchdog_wake_out <= 1'b0;
		end else begin
			reg_reset_out <= state_d != ST_RUN &&
				!(state_d == ST_OSU && two_speed);
			use_internal_osc_out <= state_d == ST_OSU && two_speed;
			watchdog_wake_out <= wake_ev;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			brownout_detect_en_out <= 1'b0;
			ext_reset_pin_out <= 1'b0;
			ext_reset_pin_oe_n_out <= 1'b1;
			ext_reset_pin_pullup_out <= 1'b0;
			prog_voltage_en_out <= 1'b1;
		end else begin
			brownout_detect_en_out <= bor_active;
			ext_reset_pin_out <= 1'b0;
			ext_reset_pin_oe_n_out <= 1'b1;
			ext_reset_pin_pullup_out <= !fuses_in.ext_reset_pin_enable;
			prog_voltage_en_out <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Calibration word
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cal_q <= '0;
			prog_rd_data_out <= '0;
		end else begin
			if (prog_mode_in && prog_wr_in && prog_addr_in == CAL_WORD_ADDR) begin
				cal_q <= prog_data_in;
			end
			prog_rd_data_out <= (prog_mode_in &&
				prog_addr_in == CAL_WORD_ADDR) ? cal_q : '0;
		end
	end

	assign bor_cal_out = cal_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_rearm_to_por: assert property (
		rearm_trip |=> state_q == ST_POR && !flags_out.por_flag_n)
		else $error("rearm did not restart power-on reset");

	a_wake_no_reset: assert property (
		state_q == ST_RUN && wake_ev && !rearm_trip && !bor_trip |=>
		state_q == ST_RUN && !reg_reset_out)
		else $error("watchdog wake reset the registers");

	a_pin_not_driven: assert property (ext_reset_pin_oe_n_out)
		else $error("reset pin driven");

	a_pud_holds: assert property (
		state_q == ST_PUD |-> pud_en && reg_reset_out)
		else $error("delay timer ran while disabled or released");

	a_pud_restart: assert property (
		state_q == ST_PUD && bor_active && !supply_above_bor_in &&
		!rearm_trip |=> state_q == ST_BOR_WAIT && tmr_q == '0 &&
		reset_cause_out == CAUSE_BOR)
		else $error("dip during delay did not restart");

	a_osu_crystal: assert property (state_q == ST_OSU |-> crystal)
		else $error("oscillator timer outside crystal mode");

	a_two_speed_run: assert property (
		state_q == ST_OSU && two_speed && $past(state_q) == ST_OSU |->
		use_internal_osc_out && !reg_reset_out)
		else $error("core held during two-speed start-up");

	a_bor_mode_off: assert property (
		fuses_in.brownout_mode_select == BOR_MODE_OFF |=>
		!brownout_detect_en_out)
		else $error("brown-out enabled in mode 00");

	a_pullup_fuse: assert property (
		!fuses_in.ext_reset_pin_enable |=>
		ext_reset_pin_pullup_out && prog_voltage_en_out)
		else $error("pull-up missing with internal reset option");

	a_pin_release: assert property (
		state_q == ST_PIN_HOLD && !pin_low && !rearm_trip && !bor_trip &&
		(!bor_active || supply_above_bor_in) |=>
		state_q == ST_RUN && !reg_reset_out)
		else $error("pin release did not run at once");

	c_powerup_run: cover property ($past(state_q) == ST_PUD &&
		state_q == ST_RUN);
	c_bor_restart: cover property (state_q == ST_PUD ##1
		state_q == ST_BOR_WAIT);
	c_wdt_wake: cover property (watchdog_wake_out);
	c_pin_hold: cover property (state_q == ST_PIN_HOLD ##1 state_q == ST_RUN);

endmodule

// ### verif/mcu_reset_sequencer_tb.sv
module mcu_reset_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rst_seq_pkg::*;

	// ------------------------------------------------------------
	// Shortened counts
	// ------------------------------------------------------------
	localparam int SD = 4;
	localparam int PL = 5;
	localparam int OL = 8;
	localparam int PR = 3;
	localparam int FM = 2;

	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic supply_below_rearm_in = 1'b0;
	logic supply_above_por_in = 1'b0;
	logic supply_above_bor_in = 1'b1;
	logic ext_reset_pin_n_in = 1'b1;
	logic watchdog_timeout_in = 1'b0;
	logic sleeping_in = 1'b0;
	logic osc_tick_in = 1'b1;
	fuse_t fuses_in = '0;
	logic soft_brownout_enable_in = 1'b0;
	logic sw_por_flag_set_in = 1'b0;
	logic sw_bor_flag_set_in = 1'b0;
	logic prog_mode_in = 1'b0;
	logic [PROG_ADDR_W-1:0] prog_addr_in = '0;
	logic prog_wr_in = 1'b0;
	logic [CAL_WIDTH-1:0] prog_data_in = '0;
	logic [CAL_WIDTH-1:0] prog_rd_data_out;
	logic reg_reset_out;
	logic use_internal_osc_out;
	logic watchdog_wake_out;
	cause_t reset_cause_out;
	flags_t flags_out;
	logic brownout_detect_en_out;
	logic [CAL_WIDTH-1:0] bor_cal_out;
	logic ext_reset_pin_out;
	logic ext_reset_pin_oe_n_out;
	logic ext_reset_pin_pullup_out;
	logic prog_voltage_en_out;
	int error_cnt = 0;
	int cmp_count = 0;
	int n;
	int lo;
	logic seen;

	always #5 core_clk_in = ~core_clk_in;

	mcu_reset_sequencer #(.SLOW_DIV(SD), .PUD_LEN(PL), .OSU_LEN(OL),
		.POR_DLY(PR), .BOR_MIN(FM), .REARM_MIN(FM), .PIN_MIN(FM),
		.CAL_W(CAL_WIDTH)) mcu_reset_sequencer_inst (
		.core_clk_in, .reset_n_in, .supply_below_rearm_in,
		.supply_above_por_in, .supply_above_bor_in, .ext_reset_pin_n_in,
		.watchdog_timeout_in, .sleeping_in, .osc_tick_in, .fuses_in,
		.soft_brownout_enable_in, .sw_por_flag_set_in, .sw_bor_flag_set_in,
		.prog_mode_in, .prog_addr_in, .prog_wr_in, .prog_data_in,
		.prog_rd_data_out, .reg_reset_out, .use_internal_osc_out,
		.watchdog_wake_out, .reset_cause_out, .flags_out,
		.brownout_detect_en_out, .bor_cal_out, .ext_reset_pin_out,
		.ext_reset_pin_oe_n_out, .ext_reset_pin_pullup_out,
		.prog_voltage_en_out);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic tick(input int k = 1);
		repeat (k) @(posedge core_clk_in);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int v, input int a, input int b);
		chk({15'h0, (v >= a && v <= b)}, 16'h1);
	endtask

	task automatic wait_rst(input logic v, output int k);
		k = 0;
		while (reg_reset_out !== v && k < 2000) begin
			tick();
			k++;
		end
		if (reg_reset_out !== v) begin
			error_cnt++;
			$display("[ERR] %0t got %0h exp %0h", $time, reg_reset_out, v);
		end
	endtask

	function automatic fuse_t mk(input logic pe, input logic pw,
		input logic [1:0] bm, input osc_mode_t om, input logic ts);
		return '{pe, pw, bm, om, ts, 1'b0};
	endfunction

	task automatic power_up(input fuse_t f, input logic pin_n,
		output int k);
		reset_n_in = 1'b0;
		fuses_in = f;
		supply_above_por_in = 1'b0;
		ext_reset_pin_n_in = pin_n;
		tick(8);
		reset_n_in = 1'b1;
		tick();
		supply_above_por_in = 1'b1;
		k = 0;
		if (pin_n) begin
			wait_rst(1'b0, k);
		end else begin
			tick(PR + (PL + 1) * SD + OL + 10);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		tick(8);
		chk(reg_reset_out, 1'b1);
		chk(ext_reset_pin_oe_n_out, 1'b1);
		chk(prog_voltage_en_out, 1'b1);
		for (int m = 0; m < 8; m++) begin
			power_up(mk(1'b1, m[0], BOR_MODE_ON, osc_mode_t'(m[2:1]),
				1'b0), 1'b1, n);
			lo = PR + (m[0] ? 0 : (PL - 1) * SD);
			lo += (m[2:1] == 2'h0) ? OL : 0;
			chk_rng(n, lo, lo + SD + 8);
		end
		chk(reset_cause_out, CAUSE_POR);
		chk(flags_out.por_flag_n, 1'b0);
		for (int m = 0; m < 4; m++) begin
			power_up(mk(1'b1, 1'b1, m[1:0], OSC_RC, 1'b0), 1'b1, n);
			tick(2);
			chk(brownout_detect_en_out, m >= 2);
			soft_brownout_enable_in = 1'b1;
			tick(2);
			chk(brownout_detect_en_out, m != 0);
			sleeping_in = 1'b1;
			tick(2);
			chk(brownout_detect_en_out, m[0]);
			sleeping_in = 1'b0;
			soft_brownout_enable_in = 1'b0;
			tick(2);
		end
		power_up(mk(1'b1, 1'b0, BOR_MODE_ON, OSC_CRYSTAL, 1'b1),
			1'b1, n);
		chk(use_internal_osc_out, 1'b1);
		tick(OL + 4);
		chk(use_internal_osc_out, 1'b0);
		power_up(mk(1'b0, 1'b0, BOR_MODE_ON, OSC_RC, 1'b0), 1'b1, n);
		chk(ext_reset_pin_pullup_out, 1'b1);
		ext_reset_pin_n_in = 1'b0;
		tick(FM + 6);
		chk(reg_reset_out, 1'b0);
		power_up(mk(1'b1, 1'b0, BOR_MODE_ON, OSC_CRYSTAL, 1'b0), 1'b0, n);
		chk(reg_reset_out, 1'b1);
		ext_reset_pin_n_in = 1'b1;
		wait_rst(1'b0, n);
		chk_rng(n, 1, FM + 5);
		prog_mode_in = 1'b1;
		prog_addr_in = CAL_WORD_ADDR;
		prog_data_in = 14'h2A5C;
		prog_wr_in = 1'b1;
		tick();
		prog_addr_in = 14'h2009;
		prog_data_in = 14'h1111;
		tick();
		prog_wr_in = 1'b0;
		tick(2);
		chk(prog_rd_data_out, 14'h0000);
		prog_addr_in = CAL_WORD_ADDR;
		tick(2);
		chk(prog_rd_data_out, 14'h2A5C);
		prog_mode_in = 1'b0;
		tick(2);
		chk(prog_rd_data_out, 14'h0000);
		sw_por_flag_set_in = 1'b1;
		tick();
		sw_por_flag_set_in = 1'b0;
		tick();
		chk(flags_out.por_flag_n, 1'b1);
		ext_reset_pin_n_in = 1'b0;
		tick(FM);
		ext_reset_pin_n_in = 1'b1;
		tick(4);
		chk(reg_reset_out, 1'b0);
		ext_reset_pin_n_in = 1'b0;
		tick(FM + 4);
		chk(reg_reset_out, 1'b1);
		chk(reset_cause_out, CAUSE_PIN_RUN);
		chk(flags_out.por_flag_n, 1'b1);
		ext_reset_pin_n_in = 1'b1;
		wait_rst(1'b0, n);
		chk_rng(n, 1, FM + 5);
		watchdog_timeout_in = 1'b1;
		tick();
		watchdog_timeout_in = 1'b0;
		wait_rst(1'b1, n);
		chk_rng(n, 0, 3);
		chk({ext_reset_pin_oe_n_out, ext_reset_pin_out}, 2'h2);
		wait_rst(1'b0, n);
		chk_rng(n, 0, 6);
		chk(reset_cause_out, CAUSE_WDT_RUN);
		chk(flags_out.timeout_flag, 1'b0);
		sleeping_in = 1'b1;
		tick(2);
		watchdog_timeout_in = 1'b1;
		tick();
		watchdog_timeout_in = 1'b0;
		seen = watchdog_wake_out;
		repeat (4) begin
			tick();
			seen |= watchdog_wake_out;
			chk(reg_reset_out, 1'b0);
		end
		chk(seen, 1'b1);
		chk(reset_cause_out, CAUSE_WDT_SLEEP);
		chk({flags_out.timeout_flag, flags_out.sleep_flag_n}, 2'h0);
		sleeping_in = 1'b0;
		tick(2);
		sleeping_in = 1'b1;
		tick(2);
		ext_reset_pin_n_in = 1'b0;
		tick(FM + 4);
		chk(reset_cause_out, CAUSE_PIN_SLEEP);
		chk({flags_out.timeout_flag, flags_out.sleep_flag_n}, 2'h2);
		sleeping_in = 1'b0;
		ext_reset_pin_n_in = 1'b1;
		wait_rst(1'b0, n);
		sw_bor_flag_set_in = 1'b1;
		tick();
		sw_bor_flag_set_in = 1'b0;
		tick();
		chk(flags_out.brownout_flag_n, 1'b1);
		supply_above_bor_in = 1'b0;
		tick();
		supply_above_bor_in = 1'b1;
		tick(5);
		chk(reg_reset_out, 1'b0);
		supply_above_bor_in = 1'b0;
		tick(FM + 4);
		chk(reg_reset_out, 1'b1);
		tick(6);
		chk(reg_reset_out, 1'b1);
		supply_above_bor_in = 1'b1;
		tick(3);
		supply_above_bor_in = 1'b0;
		tick(FM + 4);
		supply_above_bor_in = 1'b1;
		wait_rst(1'b0, n);
		chk_rng(n, (PL - 1) * SD, PL * SD + OL + 10);
		chk(reset_cause_out, CAUSE_BOR);
		chk(flags_out.brownout_flag_n, 1'b0);
		supply_below_rearm_in = 1'b1;
		supply_above_por_in = 1'b0;
		supply_above_bor_in = 1'b0;
		tick(FM + 6);
		chk(reg_reset_out, 1'b1);
		chk(reset_cause_out, CAUSE_POR);
		chk(flags_out.por_flag_n, 1'b0);
		supply_below_rearm_in = 1'b0;
		supply_above_por_in = 1'b1;
		supply_above_bor_in = 1'b1;
		wait_rst(1'b0, n);
		chk_rng(n, PR, PR + PL * SD + OL + 12);
		chk(bor_cal_out, 14'h2A5C);
		finish_test();
	end
endmodule
